/* File: rtl/dag_defs.svh */
// Constants for the dynamic RAM access and refresh glue block
`ifndef DAG_DEFS_SVH
`define DAG_DEFS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define DAG_CLK_KHZ 10000
`define DAG_NS_PER_US 1000
`define DAG_KHZ_PER_GHZ 1000000
`define DAG_T_RAH_FAST_NS 30
`define DAG_T_RAH_SLOW_NS 120
`define DAG_T_ASC_NS 10

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define DAG_ADDR_CTRL 8'h00
`define DAG_ADDR_STATUS 8'h04
`define DAG_ADDR_RFCNT 8'h08
`define DAG_ADDR_REFRESHES 8'h0C
`define DAG_ADDR_LATCHED 8'h10

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DAG_CTRL_ENABLE 0
`define DAG_CTRL_SLOW_RAH 1
`define DAG_CTRL_RESET 2'h1
`define DAG_STAT_BUSY 0
`define DAG_STAT_REFRESH 1
`define DAG_STAT_WAIT 2
`define DAG_RFCNT_RESET 8'h00
`define DAG_BANK_LSB 16

`endif

/* File: rtl/dag_pkg.sv */
// Types shared by the dynamic RAM access and refresh glue block
package dag_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ROW,
      ST_COL,
      ST_CAS,
      ST_REFRESH
   } dag_state_e;
endpackage : dag_pkg

/* File: rtl/dag_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module dag_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule : dag_sync

/* File: rtl/dag_ctrl.sv */
// Dynamic RAM access sequencer, refresh counter and APB register slave
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "dag_defs.svh"
module dag_ctrl #(
   parameter int BUS_W = 16,
   parameter int Q_W = 8,
   parameter int RFC_W = 8,
   parameter int BANKS = 4
) (
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Processor side pins
   input wire logic [BUS_W-1:0] muxed_address_data_bus,
   input wire logic [1:0] bank_select,
   input wire logic cpu_address_strobe_n,
   input wire logic row_strobe_input_n,
   input wire logic refresh_mode_pin,
   input wire logic write_input_n,
   output logic cpu_wait_n,
   // Memory array side
   output logic [Q_W-1:0] ram_address,
   output logic [BANKS-1:0] row_strobe_out_n,
   output logic column_strobe_n,
   output logic write_enable_n
);
   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   function automatic int ns_to_cycles(input int ns);
      int c;
      c = (ns * `DAG_CLK_KHZ + `DAG_KHZ_PER_GHZ - 1) / `DAG_KHZ_PER_GHZ;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cycles

   localparam int RAH_FAST_CYC = ns_to_cycles(`DAG_T_RAH_FAST_NS);
   localparam int RAH_SLOW_CYC = ns_to_cycles(`DAG_T_RAH_SLOW_NS);
   localparam int ASC_CYC = ns_to_cycles(`DAG_T_ASC_NS);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int SW = BUS_W + 6;
   logic [SW-1:0] pins_s;
   logic [BUS_W-1:0] bus_s;
   logic [1:0] bank_s;
   logic as_s;
   logic row_strobe_input_n_s;
   logic rfmode_s;
   logic win_s;

   dag_sync #(
      .W(SW),
      .RST_VAL({{BUS_W{1'b0}}, 2'h0, 4'hF})
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .d({muxed_address_data_bus, bank_select, cpu_address_strobe_n,
          row_strobe_input_n, refresh_mode_pin, write_input_n}),
      .q(pins_s)
   );

   assign bus_s = pins_s[SW-1 -: BUS_W];
   assign bank_s = pins_s[5:4];
   assign as_s = pins_s[3];
   assign row_strobe_input_n_s = pins_s[2];
   assign rfmode_s = pins_s[1];
   assign win_s = pins_s[0];

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   dag_pkg::dag_state_e state;
   dag_pkg::dag_state_e next_state;
   logic as_d;
   logic next_as_d;
   logic row_strobe_input_n_d;
   logic next_row_strobe_input_n_d;
   logic [BUS_W-1:0] lat_addr;
   logic [BUS_W-1:0] next_lat_addr;
   logic [1:0] lat_bank;
   logic [1:0] next_lat_bank;
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic [RFC_W-1:0] rfcnt;
   logic [RFC_W-1:0] next_rfcnt;
   logic [15:0] refreshes;
   logic [15:0] next_refreshes;
   logic armed;
   logic next_armed;
   logic [Q_W-1:0] next_ram_address;
   logic [BANKS-1:0] next_row_strobe_out_n;
   logic next_column_strobe_n;
   logic next_write_enable_n;
   logic next_cpu_wait_n;

   // APB state
   logic [1:0] ctrl;
   logic [1:0] next_ctrl;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic apb_commit;
   logic rfcnt_wr;

   logic as_fall;
   logic row_strobe_input_n_fall;
   logic row_strobe_input_n_rise;

   assign as_fall = as_d & ~as_s;
   assign row_strobe_input_n_fall = row_strobe_input_n_d & ~row_strobe_input_n_s;
   assign row_strobe_input_n_rise = ~row_strobe_input_n_d & row_strobe_input_n_s;
   assign apb_commit = psel & penable & pready;
   assign rfcnt_wr = apb_commit & pwrite & (paddr == `DAG_ADDR_RFCNT);

   // ----------------------------------------------------------------
   // Access and refresh sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_as_d = as_s;
      next_row_strobe_input_n_d = row_strobe_input_n_s;
      next_lat_addr = lat_addr;
      next_lat_bank = lat_bank;
      next_cnt = cnt;
      next_rfcnt = rfcnt;
      next_refreshes = refreshes;
      next_armed = armed;
      next_ram_address = ram_address;
      next_row_strobe_out_n = row_strobe_out_n;
      next_column_strobe_n = column_strobe_n;
      next_write_enable_n = write_enable_n;
      next_cpu_wait_n = cpu_wait_n;

      // Address taken on the strobe's falling edge, as the bus still holds it
      if (as_fall) begin
         next_lat_addr = bus_s;
         next_lat_bank = bank_s;
      end

      case (state)
         dag_pkg::ST_IDLE: begin
            next_row_strobe_out_n = '1;
            next_column_strobe_n = 1'b1;
            next_write_enable_n = 1'b1;
            next_cpu_wait_n = 1'b1;
            next_ram_address = lat_addr[Q_W-1:0];
            if (!rfmode_s) begin
               // Refresh entry waits for a full strobe low to count a row
               next_state = dag_pkg::ST_REFRESH;
               next_armed = 1'b0;
               next_ram_address = rfcnt;
            end else if (row_strobe_input_n_fall && ctrl[`DAG_CTRL_ENABLE]) begin
               next_row_strobe_out_n[lat_bank] = 1'b0;
               next_write_enable_n = win_s;
               next_cpu_wait_n = 1'b0;
               next_cnt = ctrl[`DAG_CTRL_SLOW_RAH] ? 3'(RAH_SLOW_CYC - 1)
                                                  : 3'(RAH_FAST_CYC - 1);
               next_state = dag_pkg::ST_ROW;
            end
         end
         dag_pkg::ST_ROW: begin
            next_write_enable_n = win_s;
            if (row_strobe_input_n_s) begin
               next_state = dag_pkg::ST_IDLE;
               next_row_strobe_out_n = '1;
               next_cpu_wait_n = 1'b1;
            end else if (cnt == 3'h0) begin
               next_ram_address = lat_addr[2*Q_W-1:Q_W];
               next_cnt = 3'(ASC_CYC - 1);
               next_state = dag_pkg::ST_COL;
            end else begin
               next_cnt = cnt - 3'h1;
            end
         end
         dag_pkg::ST_COL: begin
            next_write_enable_n = win_s;
            if (row_strobe_input_n_s) begin
               next_state = dag_pkg::ST_IDLE;
               next_row_strobe_out_n = '1;
               next_cpu_wait_n = 1'b1;
            end else if (cnt == 3'h0) begin
               next_column_strobe_n = 1'b0;
               next_cpu_wait_n = 1'b1;
               next_state = dag_pkg::ST_CAS;
            end else begin
               next_cnt = cnt - 3'h1;
            end
         end
         dag_pkg::ST_CAS: begin
            // Write input is tracked so a late early-write still reaches the array
            next_write_enable_n = win_s;
            if (row_strobe_input_n_s) begin
               next_row_strobe_out_n = '1;
               next_column_strobe_n = 1'b1;
               next_write_enable_n = 1'b1;
               next_state = dag_pkg::ST_IDLE;
            end
         end
         dag_pkg::ST_REFRESH: begin
            next_ram_address = rfcnt;
            next_row_strobe_out_n = {BANKS{row_strobe_input_n_s}};
            next_column_strobe_n = 1'b1;
            next_write_enable_n = 1'b1;
            next_cpu_wait_n = 1'b1;
            if (!row_strobe_input_n_s) begin
               next_armed = 1'b1;
            end
            if (row_strobe_input_n_rise && armed) begin
               next_rfcnt = rfcnt + 1'b1;
               next_ram_address = rfcnt + 1'b1;
               next_refreshes = refreshes + 16'h0001;
               next_armed = 1'b0;
            end
            // Leave only with the strobe high so no bank is cut short
            if (rfmode_s && row_strobe_input_n_s) begin
               next_state = dag_pkg::ST_IDLE;
               next_row_strobe_out_n = '1;
            end
         end
         default: begin
            next_state = dag_pkg::ST_IDLE;
         end
      endcase

      // Software preset of the row counter wins over an increment
      if (rfcnt_wr) begin
         next_rfcnt = pwdata[RFC_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= dag_pkg::ST_IDLE;
         as_d <= 1'b1;
         row_strobe_input_n_d <= 1'b1;
         lat_addr <= '0;
         lat_bank <= 2'h0;
         cnt <= 3'h0;
         rfcnt <= `DAG_RFCNT_RESET;
         refreshes <= 16'h0000;
         armed <= 1'b0;
         ram_address <= '0;
         row_strobe_out_n <= '1;
         column_strobe_n <= 1'b1;
         write_enable_n <= 1'b1;
         cpu_wait_n <= 1'b1;
      end else begin
         state <= next_state;
         as_d <= next_as_d;
         row_strobe_input_n_d <= next_row_strobe_input_n_d;
         lat_addr <= next_lat_addr;
         lat_bank <= next_lat_bank;
         cnt <= next_cnt;
         rfcnt <= next_rfcnt;
         refreshes <= next_refreshes;
         armed <= next_armed;
         ram_address <= next_ram_address;
         row_strobe_out_n <= next_row_strobe_out_n;
         column_strobe_n <= next_column_strobe_n;
         write_enable_n <= next_write_enable_n;
         cpu_wait_n <= next_cpu_wait_n;
      end
   end

   // ----------------------------------------------------------------
   // APB register slave
   // ----------------------------------------------------------------
   always_comb begin
      next_ctrl = ctrl;
      next_prdata = prdata;
      next_pslverr = 1'b0;
      // One wait cycle in the access phase keeps pready a flop output
      next_pready = psel & penable & ~pready;
      if (psel && penable && !pready) begin
         next_prdata = 32'h0000_0000;
         if (paddr == `DAG_ADDR_CTRL) begin
            next_prdata[1:0] = ctrl;
         end else if (paddr == `DAG_ADDR_STATUS) begin
            next_prdata[`DAG_STAT_BUSY] = (state != dag_pkg::ST_IDLE);
            next_prdata[`DAG_STAT_REFRESH] = (state == dag_pkg::ST_REFRESH);
            next_prdata[`DAG_STAT_WAIT] = ~cpu_wait_n;
         end else if (paddr == `DAG_ADDR_RFCNT) begin
            next_prdata[RFC_W-1:0] = rfcnt;
         end else if (paddr == `DAG_ADDR_REFRESHES) begin
            next_prdata[15:0] = refreshes;
         end else if (paddr == `DAG_ADDR_LATCHED) begin
            next_prdata[BUS_W-1:0] = lat_addr;
            next_prdata[`DAG_BANK_LSB +: 2] = lat_bank;
         end else begin
            next_pslverr = 1'b1;
         end
      end
      if (apb_commit && pwrite && paddr == `DAG_ADDR_CTRL) begin
         next_ctrl = pwdata[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= `DAG_CTRL_RESET;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end
endmodule : dag_ctrl

/* File: test/dag_ctrl_sva.sv */
// Port assertions for the access and refresh sequencer
`timescale 1ns/1ps
module dag_chk #(
   parameter int Q_W = 8,
   parameter int BANKS = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic row_strobe_input_n,
   input wire logic refresh_mode_pin,
   input wire logic cpu_wait_n,
   input wire logic [Q_W-1:0] ram_address,
   input wire logic [BANKS-1:0] row_strobe_out_n,
   input wire logic column_strobe_n
);
   // ----------------------------------------------------------------
   // Strobe ordering and wait state
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_CAS_NEEDS_RAS: assert property (!column_strobe_n |-> !(&row_strobe_out_n))
      else $error("column strobe low without a row strobe");
   AST_CAS_AFTER_RAS: assert property ($fell(column_strobe_n) |-> !(&$past(row_strobe_out_n)))
      else $error("column strobe fell before any row strobe");
   AST_COL_HOLD: assert property (!column_strobe_n && !$past(column_strobe_n) |-> $stable(ram_address))
      else $error("address moved while column strobe low");
   AST_WAIT_TO_CAS: assert property ($fell(cpu_wait_n) |-> ##[2:3] $fell(column_strobe_n))
      else $error("wait state longer than allowed");
   AST_WAIT_ENDS: assert property ($fell(column_strobe_n) |-> $rose(cpu_wait_n))
      else $error("wait not released by column strobe");
   AST_WAIT_BEFORE_CAS: assert property (!cpu_wait_n |-> column_strobe_n)
      else $error("wait held during column strobe");
   AST_RELEASE: assert property (row_strobe_input_n [*5] |-> (&row_strobe_out_n) && column_strobe_n)
      else $error("strobes active without row strobe input");
   AST_REFRESH_ALL: assert property ((!refresh_mode_pin) [*5] |-> row_strobe_out_n == '0 || &row_strobe_out_n)
      else $error("refresh row strobes not all together");
   AST_REFRESH_NO_CAS: assert property (row_strobe_out_n == '0 |-> column_strobe_n)
      else $error("column strobe during refresh");
   AST_ONE_BANK: assert property (refresh_mode_pin [*5] |-> $countones(~row_strobe_out_n) <= 1)
      else $error("more than one bank in auto access");
endmodule : dag_chk

bind dag_ctrl dag_chk #(.Q_W(Q_W), .BANKS(BANKS)) dag_chk_i (
   .clk(clk), .rst(rst), .row_strobe_input_n(row_strobe_input_n),
   .refresh_mode_pin(refresh_mode_pin), .cpu_wait_n(cpu_wait_n), .ram_address(ram_address),
   .row_strobe_out_n(row_strobe_out_n), .column_strobe_n(column_strobe_n)
);

/* File: test/dag_cpu.sv */
// Processor bus model driving the controller's pin side
`timescale 1ns/1ps
module dag_cpu (
   input wire logic clk,
   input wire logic column_strobe_n,
   output logic [15:0] muxed_address_data_bus,
   output logic [1:0] bank_select,
   output logic cpu_address_strobe_n,
   output logic row_strobe_input_n,
   output logic refresh_mode_pin,
   output logic write_input_n,
   output logic cpu_data_strobe_n,
   output logic low_byte_column_strobe_n,
   output logic high_byte_column_strobe_n
);
   logic [1:0] lanes_n;

   // Byte lanes see the column strobe only while the data strobe is low
   assign low_byte_column_strobe_n = column_strobe_n | cpu_data_strobe_n | lanes_n[0];
   assign high_byte_column_strobe_n = column_strobe_n | cpu_data_strobe_n | lanes_n[1];

   initial begin
      cpu_data_strobe_n = 1'b1;
      lanes_n = 2'h3;
      muxed_address_data_bus = 16'h0000;
      bank_select = 2'h0;
      cpu_address_strobe_n = 1'b1;
      row_strobe_input_n = 1'b1;
      refresh_mode_pin = 1'b1;
      write_input_n = 1'b1;
   end
   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   task automatic start_access(input logic [15:0] a, input logic [1:0] b, input logic wr,
      input logic [1:0] lanes);
      @(posedge clk);
      lanes_n <= ~lanes;
      muxed_address_data_bus <= a;
      bank_select <= b;
      cpu_address_strobe_n <= 1'b0;
      write_input_n <= ~wr;
      @(posedge clk);
      cpu_address_strobe_n <= 1'b1;
      row_strobe_input_n <= 1'b0;
      cpu_data_strobe_n <= 1'b0;
   endtask : start_access
   task automatic end_access();
      @(posedge clk);
      row_strobe_input_n <= 1'b1;
      write_input_n <= 1'b1;
      cpu_data_strobe_n <= 1'b1;
      lanes_n <= 2'h3;
      // Released bus no longer shows the old address
      muxed_address_data_bus <= ~muxed_address_data_bus;
      repeat (4) @(posedge clk);
   endtask : end_access
   task automatic refresh_mode(input logic on);
      @(posedge clk);
      refresh_mode_pin <= ~on;
      repeat (4) @(posedge clk);
   endtask : refresh_mode
   task automatic strobe(input logic level);
      @(posedge clk);
      row_strobe_input_n <= level;
      repeat (3) @(posedge clk);
   endtask : strobe
endmodule : dag_cpu

/* File: test/test_dag_ctrl.sv */
// Self-checking bench for the access and refresh sequencer
`timescale 1ns/1ps
`include "dag_defs.svh"
module test_dag_ctrl;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [15:0] bus;
   logic [1:0] bank;
   logic as_n;
   logic rs_n;
   logic rmode;
   logic win_n;
   logic cpu_wait_n;
   logic [7:0] ram_address;
   logic [3:0] row_strobe_out_n;
   logic column_strobe_n;
   logic write_enable_n;
   logic cas_lo_n;
   logic cas_hi_n;
   logic [31:0] rd;
   logic er;
   int err_total = 0;
   int tests_run = 0;

   always #50 clk = ~clk;

   dag_ctrl dag_ctrl_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .muxed_address_data_bus(bus), .bank_select(bank), .cpu_address_strobe_n(as_n),
      .row_strobe_input_n(rs_n), .refresh_mode_pin(rmode), .write_input_n(win_n),
      .cpu_wait_n(cpu_wait_n), .ram_address(ram_address), .row_strobe_out_n(row_strobe_out_n),
      .column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n));
   dag_cpu dag_cpu_i (.clk(clk), .column_strobe_n(column_strobe_n),
      .muxed_address_data_bus(bus), .bank_select(bank),
      .cpu_address_strobe_n(as_n), .row_strobe_input_n(rs_n), .refresh_mode_pin(rmode),
      .write_input_n(win_n), .cpu_data_strobe_n(), .low_byte_column_strobe_n(cas_lo_n),
      .high_byte_column_strobe_n(cas_hi_n));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, pready, 1'b1);
         final_report();
      end
   endtask : apb
   // Polls the memory strobes a little after each edge, bounded
   task automatic wait_out(input logic [3:0] ras, input logic cas);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while ((row_strobe_out_n !== ras || column_strobe_n !== cas) && n < 20);
      if (row_strobe_out_n !== ras || column_strobe_n !== cas) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, {row_strobe_out_n, column_strobe_n},
            {ras, cas});
         final_report();
      end
   endtask : wait_out

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      cmp({25'h0, row_strobe_out_n, column_strobe_n, cpu_wait_n, write_enable_n}, 32'h7F);
      cmp({24'h0, ram_address}, 32'h0);
      apb(1'b0, `DAG_ADDR_RFCNT, 32'h0);
      cmp(rd, 32'h0);
      apb(1'b1, 8'h20, 32'hFFFF_FFFF);
      cmp({31'h0, er}, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      cmp({31'h0, er}, 32'h1);
      cmp(rd, 32'h0);
   endtask : t_reset
   // With the enable bit clear a strobe must not start any access
   task automatic t_off();
      apb(1'b1, `DAG_ADDR_CTRL, 32'h0);
      apb(1'b0, `DAG_ADDR_CTRL, 32'h0);
      cmp(rd, 32'h0);
      dag_cpu_i.start_access(16'h1234, 2'h1, 1'b0, 2'h3);
      repeat (6) @(posedge clk);
      cmp({27'h0, row_strobe_out_n, cpu_wait_n}, 32'h1F);
      dag_cpu_i.end_access();
   endtask : t_off
   task automatic t_access(input logic slow, input logic [15:0] a, input logic [1:0] b,
      input logic wr);
      logic [3:0] ras;
      logic [1:0] lanes;
      ras = ~(4'h1 << b);
      lanes = wr ? {a[0], ~a[0]} : 2'h3;
      apb(1'b1, `DAG_ADDR_CTRL, {30'h0, slow, 1'b1});
      apb(1'b0, `DAG_ADDR_CTRL, 32'h0);
      cmp(rd, {30'h0, slow, 1'b1});
      dag_cpu_i.start_access(a, b, wr, lanes);
      wait_out(ras, 1'b1);
      cmp({23'h0, cpu_wait_n, ram_address}, {23'h0, 1'b0, a[7:0]});
      wait_out(ras, 1'b0);
      cmp({22'h0, cpu_wait_n, write_enable_n, ram_address}, {22'h0, 1'b1, ~wr, a[15:8]});
      cmp({30'h0, cas_hi_n, cas_lo_n}, {30'h0, ~lanes});
      dag_cpu_i.end_access();
      cmp({28'h0, row_strobe_out_n}, 32'hF);
      cmp({30'h0, cas_hi_n, cas_lo_n}, 32'h3);
      apb(1'b0, `DAG_ADDR_LATCHED, 32'h0);
      cmp(rd, {14'h0, b, a});
   endtask : t_access
   task automatic t_refresh();
      apb(1'b1, `DAG_ADDR_RFCNT, 32'h0000_00FF);
      // Status-only cycle: refresh pin low with no strobe
      dag_cpu_i.refresh_mode(1'b1);
      dag_cpu_i.refresh_mode(1'b0);
      apb(1'b0, `DAG_ADDR_RFCNT, 32'h0);
      cmp(rd, 32'hFF);
      dag_cpu_i.refresh_mode(1'b1);
      for (int i = 0; i < 3; i++) begin
         dag_cpu_i.strobe(1'b0);
         wait_out(4'h0, 1'b1);
         cmp({24'h0, ram_address}, (32'hFF + i) & 32'hFF);
         dag_cpu_i.strobe(1'b1);
      end
      repeat (8) @(posedge clk);
      cmp({28'h0, row_strobe_out_n}, 32'hF);
      apb(1'b0, `DAG_ADDR_RFCNT, 32'h0);
      cmp(rd, 32'h2);
      apb(1'b0, `DAG_ADDR_STATUS, 32'h0);
      cmp(rd, 32'h3);
      dag_cpu_i.refresh_mode(1'b0);
      apb(1'b0, `DAG_ADDR_REFRESHES, 32'h0);
      cmp(rd, 32'h3);
   endtask : t_refresh

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_reset();
      t_off();
      t_access(1'b0, 16'hA35C, 2'h2, 1'b0);
      t_access(1'b1, 16'h5AC3, 2'h1, 1'b1);
      t_refresh();
      t_access(1'b0, 16'h0FF0, 2'h3, 1'b1);
      t_access(1'b1, 16'hF00F, 2'h0, 1'b0);
      final_report();
   end
endmodule : test_dag_ctrl
